// ---- core/lbs_pkg.sv ----
package lbs_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS         = 1000000;
    localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;
    localparam int UV_FILTER_MS  = 50;
    localparam int RST_BASE_MS   = 2;
    localparam int RST_STEP_MS   = 2;
    localparam int SHAPE_STEP_MS = 5;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_VOLT   = 8'h04;
    localparam logic [7:0] OFS_TIMING = 8'h08;
    localparam logic [7:0] OFS_CONFIG = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    localparam int CTRL_SS_POS    = 0;
    localparam int VOLT_COLD_POS  = 0;
    localparam int VOLT_WARM_POS  = 8;
    localparam int TIM_RST_POS    = 0;
    localparam int TIM_SHAPE_POS  = 8;
    localparam int CFG_RSTN_THRESHOLD_SEL_POS  = 0;
    localparam int CFG_GIP_POS    = 1;

    localparam logic [2:0] SS_RST    = 3'h0;
    localparam logic [3:0] COLD_RST  = 4'h0;
    localparam logic [3:0] WARM_RST  = 4'h0;
    localparam logic [2:0] RSTD_RST  = 3'h0;
    localparam logic [2:0] SHAPE_RST = 3'h0;
    localparam logic       RSTN_THRESHOLD_SEL_RST = 1'b0;
    localparam logic       GIP_RST   = 1'b0;

    // cold code 0 is 25 V, warm code 0 is 16 V
    localparam logic [4:0] COLD_WARM_OFS = 5'h09;

    typedef struct packed {
        logic [2:0] softstart_sel;
        logic [3:0] cold_sel;
        logic [3:0] warm_sel;
        logic [2:0] rst_dur_sel;
        logic [2:0] shape_dly_sel;
        logic       rstn_threshold_sel;
        logic       gate_in_panel_sel;
    } lbs_cfg_s;

    typedef enum logic [6:0] {
        SEQ_IDLE  = 7'b0000001,
        SEQ_SRC   = 7'b0000010,
        SEQ_GATE  = 7'b0000100,
        SEQ_DLY   = 7'b0001000,
        SEQ_RUN   = 7'b0010000,
        SEQ_DOWN  = 7'b0100000,
        SEQ_FAULT = 7'b1000000
    } lbs_seq_e;

endpackage

// ---- core/lbs_sequencer.sv ----
`timescale 1ns/1ps
module lbs_sequencer #(
    parameter int TICK_CYCLES = lbs_pkg::TICK_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        enable_pin,
    input  wire logic        vin_above_uvlo,
    input  wire logic        vin_above_det,
    input  wire logic        source_ramp_done,
    input  wire logic        gate_ramp_done,
    input  wire logic        core_ramp_done,
    input  wire logic        rail_under_70,
    input  wire logic        rail_under_30,
    input  wire logic        gate_shape_ctrl,
    output logic             regulators_en,
    output logic             source_boost_en,
    output logic             gate_boost_en,
    output logic      [2:0]  boost_softstart_code,
    output logic      [3:0]  gate_volt_cold_code,
    output logic      [3:0]  gate_volt_warm_code,
    output logic             temp_comp_en,
    output logic             pass_switch,
    output logic             discharge_switch,
    input  wire logic        tcon_rstn_i,
    output logic             tcon_rstn_o,
    output logic             tcon_rstn_oe,
    input  wire logic        panel_bias_ready_n_i,
    output logic             panel_bias_ready_n_o,
    output logic             panel_bias_ready_n_oe
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NPIN = 11;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_m_r;
    logic [NPIN-1:0] pin_s_r;

    assign pin_raw = {panel_bias_ready_n_i, tcon_rstn_i, gate_shape_ctrl, rail_under_30, rail_under_70,
                      core_ramp_done, gate_ramp_done, source_ramp_done, vin_above_det, vin_above_uvlo,
                      enable_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pin_m_r[gi] <= 1'b0;
                    pin_s_r[gi] <= 1'b0;
                end
                else
                begin
                    pin_m_r[gi] <= pin_raw[gi];
                    pin_s_r[gi] <= pin_m_r[gi];
                end
            end
        end
    endgenerate

    logic en_s, uvlo_ok_s, det_ok_s, src_done_s, gate_done_s, core_done_s;
    logic uv_s, sc_s, shape_s, rst_pin_s, ready_pin_s;
    assign en_s        = pin_s_r[0];
    assign uvlo_ok_s   = pin_s_r[1];
    assign det_ok_s    = pin_s_r[2];
    assign src_done_s  = pin_s_r[3];
    assign gate_done_s = pin_s_r[4];
    assign core_done_s = pin_s_r[5];
    assign uv_s        = pin_s_r[6];
    assign sc_s        = pin_s_r[7];
    assign shape_s     = pin_s_r[8];
    assign rst_pin_s   = pin_s_r[9];
    assign ready_pin_s = pin_s_r[10];

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    lbs_pkg::lbs_cfg_s cfg_r;
    logic [31:0]       prdata_r;
    logic              pslverr_r;
    logic [31:0]       rd_mux;
    logic              addr_ok;
    logic              wr_en;
    logic [31:0]       status_word;

    assign wr_en  = psel && penable && pwrite;
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    always_comb
    begin
        rd_mux  = 32'h0000_0000;
        addr_ok = 1'b1;
        unique case (paddr)
            lbs_pkg::OFS_CTRL:
                rd_mux[lbs_pkg::CTRL_SS_POS +: 3] = cfg_r.softstart_sel;
            lbs_pkg::OFS_VOLT:
            begin
                rd_mux[lbs_pkg::VOLT_COLD_POS +: 4] = cfg_r.cold_sel;
                rd_mux[lbs_pkg::VOLT_WARM_POS +: 4] = cfg_r.warm_sel;
            end
            lbs_pkg::OFS_TIMING:
            begin
                rd_mux[lbs_pkg::TIM_RST_POS +: 3]   = cfg_r.rst_dur_sel;
                rd_mux[lbs_pkg::TIM_SHAPE_POS +: 3] = cfg_r.shape_dly_sel;
            end
            lbs_pkg::OFS_CONFIG:
            begin
                rd_mux[lbs_pkg::CFG_RSTN_THRESHOLD_SEL_POS] = cfg_r.rstn_threshold_sel;
                rd_mux[lbs_pkg::CFG_GIP_POS]   = cfg_r.gate_in_panel_sel;
            end
            lbs_pkg::OFS_STATUS:
                rd_mux = status_word;
            default:
                addr_ok = 1'b0;
        endcase
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_r <= !addr_ok || (pwrite && paddr == lbs_pkg::OFS_STATUS);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r.softstart_sel      <= lbs_pkg::SS_RST;
            cfg_r.cold_sel           <= lbs_pkg::COLD_RST;
            cfg_r.warm_sel           <= lbs_pkg::WARM_RST;
            cfg_r.rst_dur_sel        <= lbs_pkg::RSTD_RST;
            cfg_r.shape_dly_sel      <= lbs_pkg::SHAPE_RST;
            cfg_r.rstn_threshold_sel <= lbs_pkg::RSTN_THRESHOLD_SEL_RST;
            cfg_r.gate_in_panel_sel  <= lbs_pkg::GIP_RST;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                lbs_pkg::OFS_CTRL:
                    cfg_r.softstart_sel <= pwdata[lbs_pkg::CTRL_SS_POS +: 3];
                lbs_pkg::OFS_VOLT:
                begin
                    cfg_r.cold_sel <= pwdata[lbs_pkg::VOLT_COLD_POS +: 4];
                    cfg_r.warm_sel <= pwdata[lbs_pkg::VOLT_WARM_POS +: 4];
                end
                lbs_pkg::OFS_TIMING:
                begin
                    cfg_r.rst_dur_sel   <= pwdata[lbs_pkg::TIM_RST_POS +: 3];
                    cfg_r.shape_dly_sel <= pwdata[lbs_pkg::TIM_SHAPE_POS +: 3];
                end
                lbs_pkg::OFS_CONFIG:
                begin
                    cfg_r.rstn_threshold_sel <= pwdata[lbs_pkg::CFG_RSTN_THRESHOLD_SEL_POS];
                    cfg_r.gate_in_panel_sel  <= pwdata[lbs_pkg::CFG_GIP_POS];
                end
                default:
                    ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // millisecond tick
    // ------------------------------------------------------------
    logic [16:0] tick_cnt_r;
    logic        ms_tick;
    assign ms_tick = (tick_cnt_r == 17'(TICK_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt_r <= 17'h0_0000;
        else if (ms_tick)
            tick_cnt_r <= 17'h0_0000;
        else
            tick_cnt_r <= tick_cnt_r + 17'h0_0001;
    end

    // ------------------------------------------------------------
    // sticky faults
    // ------------------------------------------------------------
    logic [5:0] uv_cnt_r;
    logic       uv_fault_r;
    logic       sc_fault_r;
    logic       fault;
    assign fault = uv_fault_r || sc_fault_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            uv_cnt_r <= 6'h00;
        else if (!uv_s)
            uv_cnt_r <= 6'h00;
        else if (ms_tick && uv_cnt_r != 6'(lbs_pkg::UV_FILTER_MS))
            uv_cnt_r <= uv_cnt_r + 6'h01;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            uv_fault_r <= 1'b0;
            sc_fault_r <= 1'b0;
        end
        else
        begin
            // held beyond the filter length
            if (uv_s && ms_tick && uv_cnt_r == 6'(lbs_pkg::UV_FILTER_MS))
                uv_fault_r <= 1'b1;
            if (sc_s)
                sc_fault_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // enable latch-off
    // ------------------------------------------------------------
    logic en_seen_r;
    logic en_off_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_seen_r <= 1'b0;
            en_off_r  <= 1'b0;
        end
        else
        begin
            if (en_s)
                en_seen_r <= 1'b1;
            if (en_seen_r && !en_s)
                en_off_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // power sequence
    // ------------------------------------------------------------
    lbs_pkg::lbs_seq_e seq_r;
    logic [5:0]        dly_cnt_r;
    logic [5:0]        shape_ms;
    logic              run_ok;
    logic              released;

    assign shape_ms = 6'(cfg_r.shape_dly_sel) * 6'(lbs_pkg::SHAPE_STEP_MS);
    assign run_ok   = en_s && uvlo_ok_s && !en_off_r;
    assign released = (seq_r == lbs_pkg::SEQ_RUN);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            seq_r     <= lbs_pkg::SEQ_IDLE;
            dly_cnt_r <= 6'h00;
        end
        else if (fault)
            seq_r <= lbs_pkg::SEQ_FAULT;
        else
        begin
            unique case (seq_r)
                lbs_pkg::SEQ_IDLE:
                    if (run_ok)
                        seq_r <= lbs_pkg::SEQ_SRC;
                lbs_pkg::SEQ_SRC:
                    if (!run_ok)
                        seq_r <= lbs_pkg::SEQ_DOWN;
                    else if (src_done_s)
                        seq_r <= lbs_pkg::SEQ_GATE;
                lbs_pkg::SEQ_GATE:
                begin
                    dly_cnt_r <= 6'h00;
                    if (!run_ok)
                        seq_r <= lbs_pkg::SEQ_DOWN;
                    else if (gate_done_s)
                        seq_r <= lbs_pkg::SEQ_DLY;
                end
                lbs_pkg::SEQ_DLY:
                    if (!run_ok)
                        seq_r <= lbs_pkg::SEQ_DOWN;
                    else if (dly_cnt_r >= shape_ms)
                        seq_r <= lbs_pkg::SEQ_RUN;
                    else if (ms_tick)
                        dly_cnt_r <= dly_cnt_r + 6'h01;
                lbs_pkg::SEQ_RUN:
                    if (!run_ok)
                        seq_r <= lbs_pkg::SEQ_DOWN;
                lbs_pkg::SEQ_DOWN:
                    ;
                lbs_pkg::SEQ_FAULT:
                    ;
            endcase
        end
    end

    // boost converters off when disabled (regulators follow only lockout and faults); on power-down outputs are left to decay, not discharged
    assign regulators_en   = uvlo_ok_s && !fault;
    assign source_boost_en = run_ok && !fault;
    assign gate_boost_en   = run_ok && !fault && src_done_s &&
                             (seq_r == lbs_pkg::SEQ_GATE || seq_r == lbs_pkg::SEQ_DLY ||
                              seq_r == lbs_pkg::SEQ_RUN);
    assign boost_softstart_code = cfg_r.softstart_sel;

    // ------------------------------------------------------------
    // gate voltage targets
    // ------------------------------------------------------------
    logic cold_below_warm;
    assign cold_below_warm     = (5'(cfg_r.cold_sel) + lbs_pkg::COLD_WARM_OFS) < 5'(cfg_r.warm_sel);
    assign gate_volt_warm_code = cfg_r.warm_sel;
    assign gate_volt_cold_code = cold_below_warm ? 4'(cfg_r.warm_sel - 4'h9) : cfg_r.cold_sel;
    assign temp_comp_en        = !cold_below_warm;

    // ------------------------------------------------------------
    // gate voltage shaping
    // ------------------------------------------------------------
    logic shape_d_r;
    logic pass_r;
    logic power_down;
    assign power_down = (seq_r == lbs_pkg::SEQ_DOWN) || !uvlo_ok_s;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shape_d_r <= 1'b0;
            pass_r    <= 1'b0;
        end
        else
        begin
            shape_d_r <= shape_s;
            if (power_down)
                pass_r <= 1'b1;
            else if (!released)
                pass_r <= 1'b0;
            else if (shape_s)
                pass_r <= 1'b1;
            else if (shape_d_r)
                pass_r <= 1'b0;
        end
    end

    assign pass_switch      = pass_r;
    assign discharge_switch = !pass_r;

    // ------------------------------------------------------------
    // timing controller reset
    // ------------------------------------------------------------
    logic [4:0] rst_cnt_r;
    logic [4:0] rst_ms;
    logic       rst_rel_r;
    logic       rst_pd;

    assign rst_ms = 5'(lbs_pkg::RST_BASE_MS) + 5'(cfg_r.rst_dur_sel) * 5'(lbs_pkg::RST_STEP_MS);
    assign rst_pd = cfg_r.rstn_threshold_sel ? !det_ok_s : !uvlo_ok_s;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_cnt_r <= 5'h00;
            rst_rel_r <= 1'b0;
        end
        else if (rst_rel_r)
        begin
            if (rst_pd)
                rst_rel_r <= 1'b0;
        end
        else if (core_done_s && !rst_pd)
        begin
            if (rst_cnt_r >= rst_ms)
                rst_rel_r <= 1'b1;
            else if (ms_tick)
                rst_cnt_r <= rst_cnt_r + 5'h01;
        end
        else
            rst_cnt_r <= 5'h00;
    end

    assign tcon_rstn_o  = 1'b0;
    assign tcon_rstn_oe = !rst_rel_r;

    // ------------------------------------------------------------
    // panel bias ready
    // ------------------------------------------------------------
    logic ready_low;
    assign ready_low = cfg_r.gate_in_panel_sel ? (!released || !det_ok_s)
                                               : !det_ok_s;

    assign panel_bias_ready_n_o  = 1'b0;
    assign panel_bias_ready_n_oe = ready_low;

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    always_comb
    begin
        status_word        = 32'h0000_0000;
        status_word[0]     = uv_fault_r;
        status_word[1]     = sc_fault_r;
        status_word[2]     = en_off_r;
        status_word[3]     = gate_boost_en;
        status_word[4]     = rst_rel_r;
        status_word[5]     = released;
        status_word[6]     = pass_r;
        status_word[7]     = rst_pin_s;
        status_word[8]     = ready_pin_s;
        status_word[15:9]  = seq_r;
    end

endmodule

// ---- dv/lbs_sequencer_checker.sv ----
`timescale 1ns/1ps
module lbs_sequencer_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable_pin,
    input wire logic vin_above_uvlo,
    input wire logic vin_above_det,
    input wire logic source_ramp_done,
    input wire logic rail_under_30,
    input wire logic gate_shape_ctrl,
    input wire logic regulators_en,
    input wire logic gate_boost_en,
    input wire logic pass_switch,
    input wire logic discharge_switch,
    input wire logic tcon_rstn_oe,
    input wire logic panel_bias_ready_n_oe
);
    // ------------------------------
    // properties
    // ------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_switch_pair: assert property (discharge_switch == !pass_switch)
        else $error("switch pair");
    a_gate_after_src: assert property (gate_boost_en |-> $past(source_ramp_done, 2))
        else $error("gate before source");
    a_gate_off_en: assert property (!enable_pin |-> ##2 !gate_boost_en)
        else $error("gate on, enable low");
    a_uvlo_off: assert property (!vin_above_uvlo |-> ##2 !regulators_en)
        else $error("on under lockout");
    a_short_fault: assert property (rail_under_30 |-> ##3 !regulators_en [*8])
        else $error("short not latched");
    a_reset_latched: assert property ($rose(tcon_rstn_oe) |-> !vin_above_uvlo || !vin_above_det)
        else $error("reset reasserted");
    a_panel_det: assert property (!vin_above_det [*4] |-> panel_bias_ready_n_oe)
        else $error("ready under detect");
    a_pass_cause: assert property ($rose(pass_switch) && vin_above_uvlo && enable_pin
        |-> $past(gate_shape_ctrl, 3))
        else $error("pass without shaping");

    c_pass_on: cover property ($rose(pass_switch));
    c_reset_out: cover property ($fell(tcon_rstn_oe));
    c_short: cover property (rail_under_30 ##3 !regulators_en);
endmodule

bind lbs_sequencer lbs_sequencer_checker u_checker (
    .pclk, .presetn, .enable_pin, .vin_above_uvlo, .vin_above_det, .source_ramp_done,
    .rail_under_30, .gate_shape_ctrl, .regulators_en, .gate_boost_en, .pass_switch,
    .discharge_switch, .tcon_rstn_oe, .panel_bias_ready_n_oe
);

// ---- dv/lbs_board_model.sv ----
`timescale 1ns/1ps
module lbs_board_model #(
    parameter int RAMP_CYCLES = 20,
    parameter int CORE_CYCLES = 5
) (
    input  wire logic pclk,
    input  wire logic source_boost_en,
    input  wire logic gate_boost_en,
    input  wire logic regulators_en,
    input  wire logic core_glitch,
    input  wire logic tcon_rstn_o,
    input  wire logic tcon_rstn_oe,
    input  wire logic panel_bias_ready_n_o,
    input  wire logic panel_bias_ready_n_oe,
    output logic      source_ramp_done,
    output logic      gate_ramp_done,
    output logic      core_ramp_done,
    output logic      tcon_rstn_i,
    output logic      panel_bias_ready_n_i
);
    // ------------------------------
    // converter ramps
    // ------------------------------
    int src_cnt  = 0;
    int gate_cnt = 0;
    int core_cnt = 0;

    always @(posedge pclk)
    begin
        src_cnt  <= source_boost_en ? src_cnt + 1 : 0;
        gate_cnt <= gate_boost_en ? gate_cnt + 1 : 0;
        core_cnt <= regulators_en ? core_cnt + 1 : 0;
    end

    assign source_ramp_done = src_cnt >= RAMP_CYCLES;
    assign gate_ramp_done   = gate_cnt >= RAMP_CYCLES;
    assign core_ramp_done   = core_cnt >= CORE_CYCLES && !core_glitch;

    // ------------------------------
    // pull-ups
    // ------------------------------
    assign tcon_rstn_i          = tcon_rstn_oe ? tcon_rstn_o : 1'b1;
    assign panel_bias_ready_n_i = panel_bias_ready_n_oe ? panel_bias_ready_n_o : 1'b1;
endmodule

// ---- dv/lbs_sequencer_test.sv ----
`timescale 1ns/1ps
module lbs_sequencer_test;
    // ------------------------------
    // signals
    // ------------------------------
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, enable_pin = 1'b0, vin_above_uvlo = 1'b0, vin_above_det = 1'b0;
    logic        rail_under_70 = 1'b0, rail_under_30 = 1'b0, gate_shape_ctrl = 1'b1, core_glitch = 1'b0;
    logic        source_ramp_done, gate_ramp_done, core_ramp_done, regulators_en, source_boost_en;
    logic        gate_boost_en, temp_comp_en, pass_switch, discharge_switch, tcon_rstn_i, tcon_rstn_o;
    logic        tcon_rstn_oe, panel_bias_ready_n_i, panel_bias_ready_n_o, panel_bias_ready_n_oe;
    logic [2:0]  boost_softstart_code;
    logic [3:0]  gate_volt_cold_code, gate_volt_warm_code;
    int          n_errors = 0, total_checks = 0;

    always #4 pclk = ~pclk;

    lbs_sequencer #(.TICK_CYCLES(10)) DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .enable_pin,
        .vin_above_uvlo, .vin_above_det, .source_ramp_done, .gate_ramp_done, .core_ramp_done, .rail_under_70,
        .rail_under_30, .gate_shape_ctrl, .regulators_en, .source_boost_en, .gate_boost_en, .boost_softstart_code,
        .gate_volt_cold_code, .gate_volt_warm_code, .temp_comp_en, .pass_switch, .discharge_switch, .tcon_rstn_i,
        .tcon_rstn_o, .tcon_rstn_oe, .panel_bias_ready_n_i, .panel_bias_ready_n_o, .panel_bias_ready_n_oe
    );

    lbs_board_model u_board (
        .pclk, .source_boost_en, .gate_boost_en, .regulators_en, .core_glitch, .tcon_rstn_o, .tcon_rstn_oe,
        .panel_bias_ready_n_o, .panel_bias_ready_n_oe, .source_ramp_done, .gate_ramp_done, .core_ramp_done,
        .tcon_rstn_i, .panel_bias_ready_n_i
    );

    // ------------------------------
    // shared tasks
    // ------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp, "read data");
        chk(32'(e), 32'(exp_err), "read error");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk(32'(e), 32'(exp_err), "write error");
    endtask

    task automatic wait_hi(input int which, output int n);
        n = 0;
        while ((which == 0 ? core_ramp_done : which == 1 ? tcon_rstn_i :
               which == 2 ? gate_ramp_done : pass_switch) !== 1'b1)
        begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic do_reset(input logic up);
        presetn <= 1'b0;
        enable_pin <= 1'b0;
        vin_above_uvlo <= 1'b0;
        vin_above_det <= 1'b0;
        gate_shape_ctrl <= 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        vin_above_uvlo <= up;
        vin_above_det <= up;
        enable_pin <= up;
    endtask

    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_regs;
        do_reset(1'b0);
        rd(lbs_pkg::OFS_CTRL, 32'h0, 1'b0);
        rd(lbs_pkg::OFS_TIMING, 32'h0, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        wr(lbs_pkg::OFS_STATUS, 32'hffff_ffff, 1'b1);
        wr(lbs_pkg::OFS_CTRL, 32'h7, 1'b0);
        rd(lbs_pkg::OFS_CTRL, 32'h7, 1'b0);
        chk(32'(boost_softstart_code), 32'h7, "softstart");
        wr(lbs_pkg::OFS_VOLT, 32'h0c00, 1'b0);
        chk(32'(gate_volt_cold_code), 32'h3, "cold forced");
        chk(32'(temp_comp_en), 32'h0, "comp off");
        wr(lbs_pkg::OFS_VOLT, 32'h0a05, 1'b0);
        rd(lbs_pkg::OFS_VOLT, 32'h0a05, 1'b0);
        chk(32'({gate_volt_warm_code, gate_volt_cold_code}), 32'ha5, "targets");
        chk(32'(temp_comp_en), 32'h1, "comp on");
    endtask

    task automatic t_powerup;
        int n;
        do_reset(1'b0);
        wr(lbs_pkg::OFS_TIMING, 32'h0100, 1'b0);
        wr(lbs_pkg::OFS_CONFIG, 32'h3, 1'b0);
        {vin_above_uvlo, vin_above_det, enable_pin} <= 3'b111;
        wait_hi(0, n);
        wait_hi(1, n);
        chk(32'(n >= 10 && n <= 26), 32'h1, "reset pulse");
        wait_hi(2, n);
        chk(32'({pass_switch, panel_bias_ready_n_i}), 32'h0, "held");
        wait_hi(3, n);
        chk(32'(n >= 40 && n <= 56), 32'h1, "shaping delay");
        chk(32'(panel_bias_ready_n_i), 32'h1, "ready");
        gate_shape_ctrl <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(32'({pass_switch, discharge_switch}), 32'h1, "shaping fall");
        gate_shape_ctrl <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(32'({pass_switch, discharge_switch}), 32'h2, "shaping high");
        core_glitch <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(32'(tcon_rstn_i), 32'h1, "reset latched");
        core_glitch <= 1'b0;
        vin_above_det <= 1'b0;
        gate_shape_ctrl <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(32'({tcon_rstn_i, panel_bias_ready_n_i}), 32'h0, "detect drop");
        vin_above_uvlo <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(32'({gate_boost_en, pass_switch}), 32'h1, "power-down");
    endtask

    task automatic t_latch;
        do_reset(1'b1);
        repeat (10) @(posedge pclk);
        chk(32'(source_boost_en), 32'h1, "boost on");
        enable_pin <= 1'b0;
        repeat (10) @(posedge pclk);
        enable_pin <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(32'({source_boost_en, gate_boost_en}), 32'h0, "latched off");
    endtask

    task automatic t_faults;
        int n;
        do_reset(1'b1);
        wait_hi(1, n);
        vin_above_det <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(32'({tcon_rstn_i, panel_bias_ready_n_i}), 32'h2, "lockout mode");
        vin_above_det <= 1'b1;
        rail_under_70 <= 1'b1;
        repeat (400) @(posedge pclk);
        chk(32'(regulators_en), 32'h1, "short dip");
        rail_under_70 <= 1'b0;
        @(posedge pclk);
        rail_under_70 <= 1'b1;
        repeat (560) @(posedge pclk);
        rail_under_70 <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(32'(regulators_en), 32'h0, "uv fault");
        do_reset(1'b1);
        repeat (10) @(posedge pclk);
        chk(32'(regulators_en), 32'h1, "cleared");
        rail_under_30 <= 1'b1;
        @(posedge pclk);
        rail_under_30 <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(32'({regulators_en, source_boost_en}), 32'h0, "short");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        t_regs();
        t_powerup();
        t_latch();
        t_faults();
        tally_and_finish();
    end

    initial
    begin
        #(8 * 20000);
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule
